/* File: verilog/rvs_cmd_core.sv */
// Task-file command engine: sector read, verify, recalibrate, request sense
// Function
// - Opcode 20h or 21h reads 1 to 256 sectors from transfer length
// - Transfer length zero means 256 sectors for read and verify
// - Transfer starts at the address held in the address registers
// - Per sector: busy, load buffer, data request, clear busy, interrupt
// - After good read, address registers show the last sector read
// - On read error stop and keep failing sector address
// - After read error the failing sector stays in the buffer
// - Opcode 40h or 41h verifies like read but never requests data
// - Verify sets busy on accept, clears busy and interrupts at end
// - After good verify, address registers show last sector verified
// - Verify error keeps failing address and unverified count
// - Any opcode 1Xh completes without media access and clears the extended error code
// - Opcode 03h puts previous extended error code into error register
// - Extended codes 00h none, 01h self-test good, 09h miscellaneous
// - Codes 20h bad command, 21h bad address, 2Fh address overflow
// - Codes 11h uncorrectable, 18h corrected ECC, 1Fh aborted transfer
// - Self-test failures 05h, 30h-34h, 37h, 3Eh; voltage 35h, 36h
// - Media codes 10h, 14h, 3Ah, 0Ch, 38h, 3Bh, 3Ch, 3Fh, 03h
// - Code 22h reports power level 1 disabled
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module rvs_cmd_core (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  output logic                       bsy_o,
  output logic                       drq_o,
  output logic                       intrq_o,
  output rvs_pkg::rvs_med_req_t      med_req,
  input  wire rvs_pkg::rvs_med_rsp_t med_rsp
);

  rvs_pkg::rvs_state_t   state_r;
  rvs_pkg::rvs_med_req_t med_req_r;

  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        bsy_r;
  logic        drq_r;
  logic        intrq_r;
  logic        errflag_r;
  logic        verify_r;
  logic [7:0]  err_r;
  logic [7:0]  ext_r;
  logic [9:0]  byte_cnt_r;
  logic [7:0]  feat_r;
  logic [7:0]  len_r;
  logic [7:0]  sec_r;
  logic [7:0]  cyl_lo_r;
  logic [7:0]  cyl_hi_r;
  logic [7:0]  dh_r;

  logic [2:0]  idx;
  logic        mapped;
  logic        setup_s;
  logic        done_s;
  logic        wr_s;
  logic        rd_s;
  logic        cmd_s;
  logic        data_rd_s;
  logic        last_s;
  logic        adv_s;
  logic        dec_s;
  logic        clr_s;
  logic        fail_s;
  logic [7:0]  fail_code;
  logic [7:0]  fail_err;
  logic        med_ok;
  logic        irq_set_s;
  logic        irq_clr_s;
  logic [7:0]  status;
  logic [7:0]  rd_mux;
  logic [7:0]  buf_rdata;
  logic        lba_mode;
  logic [27:0] cur_lba;
  logic [27:0] chs_lba;
  logic [27:0] eff_lba;
  logic [27:0] nxt_lba;
  logic        chs_bad;
  logic        addr_ovf;
  logic [7:0]  nxt_sec;
  logic [3:0]  nxt_head;
  logic [15:0] nxt_cyl;

  // APB decode; only word-aligned offsets inside the map hit a register, others answer with pslverr
  assign idx       = paddr[4:2];
  assign mapped    = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
  assign setup_s   = psel && !penable;
  assign done_s    = psel && penable && pready_r;
  assign wr_s      = done_s && pwrite && mapped && pstrb[0];
  assign rd_s      = done_s && !pwrite && mapped;
  assign cmd_s     = wr_s && (idx == rvs_pkg::IDX_CMD_STAT) && !bsy_r;
  assign data_rd_s = rd_s && (idx == rvs_pkg::IDX_DATA);
  // zero as 256: zero wraps to 255 after one sector
  assign last_s    = (len_r == 8'h01);

  assign lba_mode = dh_r[rvs_pkg::DH_LBA];
  assign cur_lba  = {dh_r[3:0], cyl_hi_r, cyl_lo_r, sec_r};
  assign chs_lba  = (28'({cyl_hi_r, cyl_lo_r}) * 28'(rvs_pkg::GEO_HEADS)
                    + 28'(dh_r[3:0])) * 28'(rvs_pkg::GEO_SPT)
                    + 28'(sec_r) - 28'h0000001;
  assign eff_lba  = lba_mode ? cur_lba : chs_lba;
  assign chs_bad  = !lba_mode && ((sec_r == 8'h00)
                    || (sec_r > rvs_pkg::GEO_SPT)
                    || ({1'b0, dh_r[3:0]} >= rvs_pkg::GEO_HEADS));
  assign addr_ovf = (eff_lba >= rvs_pkg::GEO_CAPACITY);
  assign nxt_lba  = cur_lba + 28'h0000001;

  // Next CHS address wraps sector, then head, then cylinder
  always_comb begin
    nxt_sec  = sec_r + 8'h01;
    nxt_head = dh_r[3:0];
    nxt_cyl  = {cyl_hi_r, cyl_lo_r};
    if (sec_r >= rvs_pkg::GEO_SPT) begin
      nxt_sec = 8'h01;
      if ({1'b0, dh_r[3:0]} >= rvs_pkg::GEO_HEADS - 5'h01) begin
        nxt_head = 4'h0;
        nxt_cyl  = nxt_cyl + 16'h0001;
      end else begin
        nxt_head = dh_r[3:0] + 4'h1;
      end
    end
  end

  // corrected ECC is reported but does not stop the command
  assign med_ok = (med_rsp.code == rvs_pkg::EXT_NONE)
               || (med_rsp.code == rvs_pkg::EXT_CORR_ECC);

  // Sequencer strobes that move the task file and the buffer
  always_comb begin
    adv_s     = 1'b0;
    dec_s     = 1'b0;
    clr_s     = 1'b0;
    fail_s    = 1'b0;
    fail_code = rvs_pkg::EXT_NONE;
    case (state_r)
      rvs_pkg::ST_LOAD: begin
        if (chs_bad) begin
          fail_s    = 1'b1;
          fail_code = rvs_pkg::EXT_INVAL_ADDR;
        end else if (addr_ovf) begin
          fail_s    = 1'b1;
          fail_code = rvs_pkg::EXT_ADDR_OVF;
        end else begin
          clr_s = 1'b1;
        end
      end
      rvs_pkg::ST_WAIT: begin
        if (med_rsp.done) begin
          if (!med_ok) begin
            fail_s    = 1'b1;
            fail_code = med_rsp.code;
          end else if (verify_r) begin
            dec_s = 1'b1;
            adv_s = !last_s;
          end
        end
      end
      rvs_pkg::ST_XFER: begin
        if (data_rd_s && (byte_cnt_r == rvs_pkg::LAST_BYTE)) begin
          dec_s = 1'b1;
          adv_s = !last_s;
        end
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    fail_err = 8'h00;
    if (fail_code == rvs_pkg::EXT_UNC_ECC) begin
      fail_err[rvs_pkg::ER_UNC] = 1'b1;
    end else if ((fail_code == rvs_pkg::EXT_IDNF_10)
              || (fail_code == rvs_pkg::EXT_IDNF_14)) begin
      fail_err[rvs_pkg::ER_IDNF] = 1'b1;
    end else begin
      fail_err[rvs_pkg::ER_ABRT] = 1'b1;
    end
  end

  // Task file; sequencer updates beat a host write in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      feat_r   <= rvs_pkg::RST_FEAT;
      len_r    <= rvs_pkg::RST_LEN;
      sec_r    <= rvs_pkg::RST_SEC;
      cyl_lo_r <= rvs_pkg::RST_CYL;
      cyl_hi_r <= rvs_pkg::RST_CYL;
      dh_r     <= rvs_pkg::RST_DH;
    end else if (adv_s || dec_s) begin
      if (dec_s) begin
        len_r <= len_r - 8'h01;
      end
      if (adv_s && lba_mode) begin
        {dh_r[3:0], cyl_hi_r, cyl_lo_r, sec_r} <= nxt_lba;
      end else if (adv_s) begin
        {cyl_hi_r, cyl_lo_r} <= nxt_cyl;
        dh_r[3:0]            <= nxt_head;
        sec_r                <= nxt_sec;
      end
    end else if (wr_s && !bsy_r) begin
      case (idx)
        rvs_pkg::IDX_FEAT_ERR: feat_r   <= pwdata[7:0];
        rvs_pkg::IDX_LEN:      len_r    <= pwdata[7:0];
        rvs_pkg::IDX_ADDR_LO:  sec_r    <= pwdata[7:0];
        rvs_pkg::IDX_ADDR_MID: cyl_lo_r <= pwdata[7:0];
        rvs_pkg::IDX_ADDR_HI:  cyl_hi_r <= pwdata[7:0];
        rvs_pkg::IDX_DRV_HEAD: dh_r     <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= rvs_pkg::ST_IDLE;
      bsy_r      <= 1'b0;
      drq_r      <= 1'b0;
      errflag_r  <= 1'b0;
      verify_r   <= 1'b0;
      err_r      <= 8'h00;
      ext_r      <= rvs_pkg::EXT_NONE;
      byte_cnt_r <= 10'h000;
      med_req_r  <= '0;
    end else begin
      med_req_r.req <= 1'b0;
      if (cmd_s) begin
        drq_r     <= 1'b0;
        errflag_r <= 1'b0;
        err_r     <= 8'h00;
        bsy_r     <= 1'b1;
        if ((pwdata[7:0] == rvs_pkg::OP_READ_A)
            || (pwdata[7:0] == rvs_pkg::OP_READ_B)) begin
          verify_r <= 1'b0;
          state_r  <= rvs_pkg::ST_LOAD;
        end else if ((pwdata[7:0] == rvs_pkg::OP_VERIFY_A)
                  || (pwdata[7:0] == rvs_pkg::OP_VERIFY_B)) begin
          verify_r <= 1'b1;
          state_r  <= rvs_pkg::ST_LOAD;
        end else if (pwdata[7:4] == rvs_pkg::OP_RECAL_HI) begin
          ext_r   <= rvs_pkg::EXT_NONE;
          state_r <= rvs_pkg::ST_DONE;
        end else if (pwdata[7:0] == rvs_pkg::OP_SENSE) begin
          err_r   <= ext_r;
          state_r <= rvs_pkg::ST_DONE;
        end else begin
          ext_r                  <= rvs_pkg::EXT_INVAL_CMD;
          err_r[rvs_pkg::ER_ABRT] <= 1'b1;
          errflag_r              <= 1'b1;
          state_r                <= rvs_pkg::ST_DONE;
        end
      end else if (fail_s) begin
        ext_r     <= fail_code;
        err_r     <= fail_err;
        errflag_r <= 1'b1;
        drq_r     <= 1'b0;
        state_r   <= rvs_pkg::ST_DONE;
      end else begin
        case (state_r)
          rvs_pkg::ST_LOAD: begin
            med_req_r.req    <= 1'b1;
            med_req_r.lba    <= eff_lba;
            med_req_r.verify <= verify_r;
            state_r          <= rvs_pkg::ST_WAIT;
          end
          rvs_pkg::ST_WAIT: begin
            if (med_rsp.done) begin
              ext_r <= med_rsp.code;
              if (verify_r) begin
                state_r <= last_s ? rvs_pkg::ST_DONE : rvs_pkg::ST_LOAD;
              end else begin
                drq_r      <= 1'b1;
                byte_cnt_r <= 10'h000;
                state_r    <= rvs_pkg::ST_PRESENT;
              end
            end
          end
          rvs_pkg::ST_PRESENT: begin
            bsy_r   <= 1'b0;
            state_r <= rvs_pkg::ST_XFER;
          end
          rvs_pkg::ST_XFER: begin
            if (data_rd_s) begin
              byte_cnt_r <= byte_cnt_r + 10'h001;
              if (byte_cnt_r == rvs_pkg::LAST_BYTE) begin
                drq_r <= 1'b0;
                if (last_s) begin
                  state_r <= rvs_pkg::ST_IDLE;
                end else begin
                  bsy_r   <= 1'b1;
                  state_r <= rvs_pkg::ST_LOAD;
                end
              end
            end
          end
          rvs_pkg::ST_DONE: begin
            bsy_r   <= 1'b0;
            state_r <= rvs_pkg::ST_IDLE;
          end
          default: begin
            state_r <= rvs_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign irq_set_s = (state_r == rvs_pkg::ST_PRESENT)
                  || (state_r == rvs_pkg::ST_DONE);
  assign irq_clr_s = cmd_s
                  || (rd_s && (idx == rvs_pkg::IDX_CMD_STAT));

  // A new event wins over a status read in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intrq_r <= 1'b0;
    end else if (irq_set_s) begin
      intrq_r <= 1'b1;
    end else if (irq_clr_s) begin
      intrq_r <= 1'b0;
    end
  end

  always_comb begin
    status                  = 8'h00;
    status[rvs_pkg::ST_BSY]  = bsy_r;
    status[rvs_pkg::ST_DRDY] = !bsy_r;
    status[rvs_pkg::ST_DSC]  = 1'b1;
    status[rvs_pkg::ST_DRQ]  = drq_r;
    status[rvs_pkg::ST_ERR]  = errflag_r;
  end

  always_comb begin
    case (idx)
      rvs_pkg::IDX_DATA:     rd_mux = buf_rdata;
      rvs_pkg::IDX_FEAT_ERR: rd_mux = err_r;
      rvs_pkg::IDX_LEN:      rd_mux = len_r;
      rvs_pkg::IDX_ADDR_LO:  rd_mux = sec_r;
      rvs_pkg::IDX_ADDR_MID: rd_mux = cyl_lo_r;
      rvs_pkg::IDX_ADDR_HI:  rd_mux = cyl_hi_r;
      rvs_pkg::IDX_DRV_HEAD: rd_mux = dh_r;
      rvs_pkg::IDX_CMD_STAT: rd_mux = status;
      default:               rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in setup so every output is a flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_s;
      if (setup_s) begin
        prdata_r  <= mapped ? {24'h000000, rd_mux} : 32'h00000000;
        pslverr_r <= !mapped;
      end
    end
  end

  rvs_sector_buf #(
    .DEPTH (512),
    .WIDTH (8)
  ) u_buf (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clr     (clr_s),
    .wr_en   (med_rsp.wvalid && (state_r == rvs_pkg::ST_WAIT)),
    .wr_data (med_rsp.wdata),
    .rd_en   (data_rd_s),
    .rd_data (buf_rdata)
  );

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign bsy_o   = bsy_r;
  assign drq_o   = drq_r;
  assign intrq_o = intrq_r;
  assign med_req = med_req_r;

endmodule

/* File: verilog/rvs_pkg.sv */
// Shared constants, types and register map of the sector command block
package rvs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA     = 3'h0;
  localparam logic [2:0] IDX_FEAT_ERR = 3'h1;
  localparam logic [2:0] IDX_LEN      = 3'h2;
  localparam logic [2:0] IDX_ADDR_LO  = 3'h3;
  localparam logic [2:0] IDX_ADDR_MID = 3'h4;
  localparam logic [2:0] IDX_ADDR_HI  = 3'h5;
  localparam logic [2:0] IDX_DRV_HEAD = 3'h6;
  localparam logic [2:0] IDX_CMD_STAT = 3'h7;

  // Opcodes
  localparam logic [7:0] OP_READ_A   = 8'h20;
  localparam logic [7:0] OP_READ_B   = 8'h21;
  localparam logic [7:0] OP_VERIFY_A = 8'h40;
  localparam logic [7:0] OP_VERIFY_B = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  localparam logic [7:0] OP_SENSE    = 8'h03;

  // Extended error codes
  localparam logic [7:0] EXT_NONE       = 8'h00;
  localparam logic [7:0] EXT_SELFTEST   = 8'h01;
  localparam logic [7:0] EXT_WR_ERASE   = 8'h03;
  localparam logic [7:0] EXT_DIAG_05    = 8'h05;
  localparam logic [7:0] EXT_MISC       = 8'h09;
  localparam logic [7:0] EXT_FMT_0C     = 8'h0C;
  localparam logic [7:0] EXT_IDNF_10    = 8'h10;
  localparam logic [7:0] EXT_UNC_ECC    = 8'h11;
  localparam logic [7:0] EXT_IDNF_14    = 8'h14;
  localparam logic [7:0] EXT_CORR_ECC   = 8'h18;
  localparam logic [7:0] EXT_ABORTED    = 8'h1F;
  localparam logic [7:0] EXT_INVAL_CMD  = 8'h20;
  localparam logic [7:0] EXT_INVAL_ADDR = 8'h21;
  localparam logic [7:0] EXT_PWR_L1_OFF = 8'h22;
  localparam logic [7:0] EXT_ADDR_OVF   = 8'h2F;
  localparam logic [7:0] EXT_VOLT_35    = 8'h35;
  localparam logic [7:0] EXT_VOLT_36    = 8'h36;
  localparam logic [7:0] EXT_SPARE_OUT  = 8'h3A;

  // Status, error and drive/head register bit positions
  localparam int unsigned ST_BSY  = 7;
  localparam int unsigned ST_DRDY = 6;
  localparam int unsigned ST_DSC  = 4;
  localparam int unsigned ST_DRQ  = 3;
  localparam int unsigned ST_ERR  = 0;
  localparam int unsigned ER_UNC  = 6;
  localparam int unsigned ER_IDNF = 4;
  localparam int unsigned ER_ABRT = 2;
  localparam int unsigned DH_LBA  = 6;

  // Sector size and media geometry
  localparam logic [9:0]  LAST_BYTE    = 10'h1FF;
  localparam logic [7:0]  GEO_SPT      = 8'h3F;
  localparam logic [4:0]  GEO_HEADS    = 5'h10;
  localparam logic [27:0] GEO_CAPACITY = 28'h0100000;

  // Values after reset
  localparam logic [7:0] RST_FEAT = 8'h00;
  localparam logic [7:0] RST_LEN  = 8'h01;
  localparam logic [7:0] RST_SEC  = 8'h01;
  localparam logic [7:0] RST_CYL  = 8'h00;
  localparam logic [7:0] RST_DH   = 8'hA0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_LOAD    = 3'b001,
    ST_WAIT    = 3'b010,
    ST_PRESENT = 3'b011,
    ST_XFER    = 3'b100,
    ST_DONE    = 3'b101
  } rvs_state_t;

  typedef struct packed {
    logic        req;
    logic        verify;
    logic [27:0] lba;
  } rvs_med_req_t;

  typedef struct packed {
    logic       wvalid;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] code;
  } rvs_med_rsp_t;

endpackage

/* File: verilog/rvs_sector_buf.sv */
// Sector buffer held in flip-flops with independent fill and drain indices
`timescale 1ns/1ps
module rvs_sector_buf #(
  parameter int unsigned DEPTH = 512,
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             clr,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_idx_r;
  logic [AW-1:0]    rd_idx_r;

  // Contents are not cleared, so a stopped load keeps its data
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_r[wr_idx_r] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
    end else if (clr) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
    end else begin
      if (wr_en) begin
        wr_idx_r <= wr_idx_r + 1'b1;
      end
      if (rd_en) begin
        rd_idx_r <= rd_idx_r + 1'b1;
      end
    end
  end

  assign rd_data = mem_r[rd_idx_r];

endmodule

/* File: verif/rvs_cmd_core_monitor.sv */
// Port-level checker for the sector command block
`timescale 1ns/1ps
module rvs_cmd_core_monitor (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  input wire logic                  bsy_o,
  input wire logic                  drq_o,
  input wire logic                  intrq_o,
  input wire rvs_pkg::rvs_med_req_t med_req,
  input wire rvs_pkg::rvs_med_rsp_t med_rsp
);
  logic [9:0] rd_cnt_r;
  logic       vfy_r;
  logic       acc;
  logic       cmd_w;
  logic       good;
  assign acc = psel && penable && pready && !pslverr;
  assign cmd_w = acc && pwrite && paddr[4:2] == 3'h7 && pstrb[0] && !bsy_o;
  assign good = med_rsp.code == 8'h00 || med_rsp.code == 8'h18;
  // Data pops counted only while a data request stands
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_cnt_r <= 10'h000;
      vfy_r <= 1'h0;
    end else begin
      rd_cnt_r <= !drq_o ? 10'h000 :
                  rd_cnt_r + 10'(acc && !pwrite && paddr[4:2] == 3'h0);
      if (med_req.req) vfy_r <= med_req.verify;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready timing");
  property p_unmapped;
    psel && !penable && !pwrite && paddr[11:5] != 7'h00
      |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
  property p_cmd_busy;
    cmd_w |=> bsy_o && !drq_o;
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("no busy");
  property p_nop_sense;
    cmd_w && (pwdata[7:4] == 4'h1 || pwdata[7:0] == 8'h03)
      |=> (bsy_o && !med_req.req) ##1 (!bsy_o && intrq_o);
  endproperty
  a_nop_sense: assert property (p_nop_sense) else $error("nop");
  property p_req_pulse;
    med_req.req |-> bsy_o && !drq_o ##1 !med_req.req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("req");
  property p_good_sector;
    med_rsp.done && good && !vfy_r
      |-> ##1 (drq_o && bsy_o) ##1 (!bsy_o && intrq_o);
  endproperty
  a_good_sector: assert property (p_good_sector) else $error("seq");
  property p_bad_sector;
    med_rsp.done && !good |-> !drq_o ##1 (bsy_o && !drq_o)
      ##1 (!bsy_o && intrq_o && !drq_o);
  endproperty
  a_bad_sector: assert property (p_bad_sector) else $error("err");
  property p_sector_len;
    $fell(drq_o) && !$past(cmd_w) |-> rd_cnt_r == 10'h200;
  endproperty
  a_sector_len: assert property (p_sector_len) else $error("len");
  property p_verify_quiet;
    vfy_r |-> !drq_o;
  endproperty
  a_verify_quiet: assert property (p_verify_quiet) else $error("drq");
endmodule
bind rvs_cmd_core rvs_cmd_core_monitor u_mon (.sys_clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
  .bsy_o, .drq_o, .intrq_o, .med_req, .med_rsp);

/* File: verif/rvs_media_model.sv */
// Behavioural flash media answering sector fetches
`timescale 1ns/1ps
module rvs_media_model (
  input wire logic                  sys_clk,
  input wire rvs_pkg::rvs_med_req_t med_req,
  input wire logic [7:0]            bad_code,
  input wire logic [27:0]           bad_lba,
  input wire logic                  slow,
  output rvs_pkg::rvs_med_rsp_t     med_rsp
);
  logic [27:0] lba_r;
  logic [9:0]  cnt_r;
  logic        busy_r = 1'h0;
  logic        stall_r = 1'h0;
  initial med_rsp = '0;
  always @(posedge sys_clk) begin
    med_rsp.done <= 1'h0;
    med_rsp.wvalid <= 1'h0;
    // Idle data toggles so a stale byte is never mistaken for fresh
    med_rsp.wdata <= ~med_rsp.wdata;
    stall_r <= ~stall_r;
    if (med_req.req) begin
      busy_r <= 1'h1;
      cnt_r <= 10'h000;
      lba_r <= med_req.lba;
    end else if (busy_r && (!slow || stall_r)) begin
      if (cnt_r == 10'h200) begin
        med_rsp.done <= 1'h1;
        med_rsp.code <= (lba_r == bad_lba) ? bad_code : 8'h00;
        busy_r <= 1'h0;
      end else begin
        med_rsp.wvalid <= 1'h1;
        med_rsp.wdata <= lba_r[7:0] ^ cnt_r[7:0];
        cnt_r <= cnt_r + 10'h001;
      end
    end
  end
endmodule

/* File: verif/rvs_cmd_core_bench.sv */
// Self-checking bench for the sector command block
`timescale 1ns/1ps
module rvs_cmd_core_bench;
  logic                  sys_clk = 1'h0;
  logic                  resetn = 1'h0;
  logic                  psel = 1'h0;
  logic                  penable = 1'h0;
  logic                  pwrite = 1'h0;
  logic [11:0]           paddr = 12'h000;
  logic [11:0]           hi = 12'h000;
  logic [31:0]           pwdata = 32'h0;
  logic [3:0]            pstrb = 4'hF;
  logic                  pready, pslverr, bsy_o, drq_o, intrq_o, er;
  logic [31:0]           prdata, rd;
  rvs_pkg::rvs_med_req_t med_req;
  rvs_pkg::rvs_med_rsp_t med_rsp;
  logic [7:0]            bad_code = 8'h00;
  logic [27:0]           bad_lba = 28'hFFFFFFF;
  logic                  slow = 1'h0;
  int                    n_fail = 0;
  int                    checks_done = 0;
  logic [7:0] rst_exp [1:7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hA0,
                                8'h50};
  logic [7:0] codes [9] = '{8'h00, 8'h18, 8'h1F, 8'h03, 8'h05, 8'h35,
                            8'h3A, 8'h22, 8'h09};
  always #5 sys_clk = ~sys_clk;
  rvs_cmd_core DUT (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .bsy_o, .drq_o, .intrq_o,
    .med_req, .med_rsp);
  rvs_media_model u_med (.sys_clk, .med_req, .bad_code, .bad_lba, .slow,
    .med_rsp);
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Idle cycle after each transfer keeps one assignment per time step
  task automatic xfer(input logic w, input logic [2:0] i,
                      input logic [7:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {7'h00, i, 2'h0} | hi;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
    if (k >= 50) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic wait_for(input logic d);
    int k;
    for (k = 0; k < 9000 && !(bsy_o === 1'h0 && drq_o === d); k++)
      @(posedge sys_clk);
    if (k == 9000) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic setup(input logic [7:0] n, input logic [27:0] l,
                       input logic [7:0] op);
    xfer(1'h1, 3'h2, n);
    xfer(1'h1, 3'h3, l[7:0]);
    xfer(1'h1, 3'h4, l[15:8]);
    xfer(1'h1, 3'h5, l[23:16]);
    xfer(1'h1, 3'h6, {4'hE, l[27:24]});
    xfer(1'h1, 3'h7, op);
  endtask
  task automatic rd_sector(input logic [27:0] l);
    for (int j = 0; j < 512; j++) begin
      xfer(1'h0, 3'h0, 8'h00);
      chk(rd, {24'h0, l[7:0] ^ 8'(j)});
    end
  endtask
  task automatic chk_addr(input logic [27:0] l, input logic [7:0] n);
    for (int i = 0; i < 3; i++) begin
      xfer(1'h0, 3'(i + 3), 8'h00);
      chk(rd, {24'h0, l[8*i +: 8]});
    end
    xfer(1'h0, 3'h2, 8'h00);
    chk(rd, {24'h0, n});
  endtask
  task automatic sense(input logic [7:0] e);
    xfer(1'h1, 3'h7, 8'h03);
    wait_for(1'h0);
    xfer(1'h0, 3'h1, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    for (int i = 1; i < 8; i++) begin
      xfer(1'h0, 3'(i), 8'h00);
      chk(rd, {24'h0, rst_exp[i]});
    end
    hi = 12'h400;
    xfer(1'h0, 3'h1, 8'h00);
    chk({31'h0, er}, 32'h1);
    hi = 12'h000;
    xfer(1'h1, 3'h7, 8'h1A);
    wait_for(1'h0);
    chk({31'h0, intrq_o}, 32'h1);
    xfer(1'h0, 3'h7, 8'h00);
    chk(rd, 32'h50);
    chk({31'h0, intrq_o}, 32'h0);
    setup(8'h02, 28'h0000123, 8'h20);
    wait_for(1'h1);
    chk({31'h0, intrq_o}, 32'h1);
    xfer(1'h0, 3'h7, 8'h00);
    chk(rd, 32'h58);
    rd_sector(28'h0000123);
    slow <= 1'h1;
    wait_for(1'h1);
    chk({31'h0, intrq_o}, 32'h1);
    rd_sector(28'h0000124);
    wait_for(1'h0);
    chk_addr(28'h0000124, 8'h00);
    bad_lba <= 28'h0000201;
    bad_code <= 8'h10;
    setup(8'h02, 28'h0000200, 8'h21);
    wait_for(1'h1);
    rd_sector(28'h0000200);
    wait_for(1'h0);
    xfer(1'h0, 3'h1, 8'h00);
    chk(rd, 32'h10);
    chk_addr(28'h0000201, 8'h01);
    // Flawed sector is still in the buffer and can be drained
    rd_sector(28'h0000201);
    sense(8'h10);
    bad_lba <= 28'h0000303;
    bad_code <= 8'h11;
    setup(8'h00, 28'h0000300, 8'h40);
    wait_for(1'h0);
    xfer(1'h0, 3'h1, 8'h00);
    chk(rd, 32'h40);
    chk_addr(28'h0000303, 8'hFD);
    sense(8'h11);
    bad_lba <= 28'h0000401;
    foreach (codes[i]) begin
      bad_code <= codes[i];
      setup(8'h02, 28'h0000400, 8'h40 | 8'(i % 2));
      wait_for(1'h0);
      chk({31'h0, intrq_o}, 32'h1);
      chk_addr(28'h0000401, (codes[i] == 8'h00 || codes[i] == 8'h18) ?
               8'h00 : 8'h01);
      sense(codes[i]);
    end
    xfer(1'h1, 3'h7, 8'h55);
    wait_for(1'h0);
    xfer(1'h0, 3'h1, 8'h00);
    chk(rd, 32'h04);
    sense(8'h20);
    xfer(1'h1, 3'h3, 8'h00);
    xfer(1'h1, 3'h6, 8'hA0);
    xfer(1'h1, 3'h7, 8'h20);
    wait_for(1'h0);
    sense(8'h21);
    setup(8'h01, 28'h0100000, 8'h20);
    wait_for(1'h0);
    sense(8'h2F);
    conclude();
  end
endmodule
